//--- rtl/pgw_pkg.sv
// Shared constants, types and decoders of the planar graphics write/read path.
// Assumes one clock domain shared by host bus, register port and map memory.
package pgw_pkg;

    // Register indexes behind the data port.
    localparam logic [3:0] IDX_SET_RESET     = 4'h0;
    localparam logic [3:0] IDX_SR_ENABLE     = 4'h1;
    localparam logic [3:0] IDX_COMPARE_COLOR = 4'h2;
    localparam logic [3:0] IDX_ROTATE_FUNC   = 4'h3;
    localparam logic [3:0] IDX_READ_PLANE    = 4'h4;
    localparam logic [3:0] IDX_MODE_CTRL     = 4'h5;
    localparam logic [3:0] IDX_WINDOW_ADDR   = 4'h6;
    localparam logic [3:0] IDX_PARTICIPATION = 4'h7;
    localparam logic [3:0] IDX_BIT_MASK      = 4'h8;
    localparam int         NUM_REGS          = 9;

    // Writable bits of each register; the rest read as zero.
    localparam logic [7:0] WMASK_NIBBLE = 8'h0F;
    localparam logic [7:0] WMASK_ROTATE = 8'h1F;
    localparam logic [7:0] WMASK_PLANE  = 8'h03;
    localparam logic [7:0] WMASK_MODE   = 8'h7B;
    localparam logic [7:0] BYTE_ONES    = 8'hFF;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;

    // Reset values.
    localparam logic [7:0] RST_REG      = 8'h00;
    localparam logic [7:0] RST_BIT_MASK = 8'hFF;

    // Field positions.
    localparam int ROT_CNT_LSB   = 0;
    localparam int ROT_FUNC_LSB  = 3;
    localparam int GM_WMODE_LSB  = 0;
    localparam int GM_READ_MODE  = 3;
    localparam int GM_ODD_EVEN   = 4;
    localparam int GM_SHIFT_IL   = 5;
    localparam int GM_SHIFT_256  = 6;
    localparam int WA_GFX        = 0;
    localparam int WA_CHAIN_OE   = 1;
    localparam int WA_WIN_LSB    = 2;

    // Write modes and logic functions.
    localparam logic [1:0] WMODE_SR     = 2'h0;
    localparam logic [1:0] WMODE_LATCH  = 2'h1;
    localparam logic [1:0] WMODE_SPREAD = 2'h2;
    localparam logic [1:0] WMODE_MASKED = 2'h3;
    localparam logic [1:0] FUNC_PASS    = 2'h0;
    localparam logic [1:0] FUNC_AND     = 2'h1;
    localparam logic [1:0] FUNC_OR      = 2'h2;
    localparam logic [1:0] FUNC_XOR     = 2'h3;

    // Buffer windows in the host address space.
    localparam logic [19:0] WIN_BASE_LOW  = 20'hA0000;
    localparam logic [19:0] WIN_BASE_MONO = 20'hB0000;
    localparam logic [19:0] WIN_BASE_ALT  = 20'hB8000;
    localparam logic [19:0] WIN_SIZE_128K = 20'h20000;
    localparam logic [19:0] WIN_SIZE_64K  = 20'h10000;
    localparam logic [19:0] WIN_SIZE_32K  = 20'h08000;

    // Host read sequencing.
    typedef enum logic [1:0] {ST_IDLE, ST_RD_ISSUE, ST_RD_DATA} pgw_state_t;

    // Writable-bit mask of a register index.
    function automatic logic [7:0] pgw_wmask(input logic [3:0] idx);
        case (idx)
            IDX_ROTATE_FUNC: pgw_wmask = WMASK_ROTATE;
            IDX_READ_PLANE:  pgw_wmask = WMASK_PLANE;
            IDX_MODE_CTRL:   pgw_wmask = WMASK_MODE;
            IDX_BIT_MASK:    pgw_wmask = BYTE_ONES;
            default:         pgw_wmask = WMASK_NIBBLE;
        endcase
    endfunction

    // Window decode: returns {hit, offset[16:0]}.
    function automatic logic [17:0] pgw_window(input logic [1:0] win, input logic [19:0] addr);
        logic [19:0] base;
        logic [19:0] size;
        logic [19:0] diff;
        case (win)
            2'h0:    begin base = WIN_BASE_LOW;  size = WIN_SIZE_128K; end
            2'h1:    begin base = WIN_BASE_LOW;  size = WIN_SIZE_64K;  end
            2'h2:    begin base = WIN_BASE_MONO; size = WIN_SIZE_32K;  end
            default: begin base = WIN_BASE_ALT;  size = WIN_SIZE_32K;  end
        endcase
        diff = addr - base;
        pgw_window = {(addr >= base) && (diff < size), diff[16:0]};
    endfunction

endpackage

//--- rtl/pgw_write_unit.sv
// Combinational write datapath: rotate, source select, logic function, bit mask.
// Assumes latches and control fields are stable registers of the caller.
module pgw_write_unit (
    // Host data and latches
    input  wire logic [7:0]  i_host_data,
    input  wire logic [31:0] i_latch,
    // Control fields
    input  wire logic [3:0]  i_set_reset,
    input  wire logic [3:0]  i_sr_enable,
    input  wire logic [2:0]  i_rotate,
    input  wire logic [1:0]  i_func,
    input  wire logic [1:0]  i_write_mode,
    input  wire logic [7:0]  i_bit_mask,
    // Result for the four maps
    output logic      [31:0] o_map_data
);
    import pgw_pkg::*;

    logic [15:0] doubled;
    logic [7:0]  rotated;

    // Circular right rotate: bits leaving position 0 come back at position 7.
    assign doubled = {i_host_data, i_host_data} >> i_rotate;
    assign rotated = doubled[7:0];

    // One lane per map.
    for (genvar n = 0; n < 4; n++) begin : g_map
        logic [7:0] lat;
        logic [7:0] src;
        logic [7:0] mask;
        logic [7:0] alu;
        assign lat = i_latch[8*n +: 8];

        // Pick the source and mask, then combine with the latch.
        always_comb begin
            src  = rotated;
            mask = i_bit_mask;
            case (i_write_mode)
                WMODE_SR:     src = i_sr_enable[n] ? {8{i_set_reset[n]}} : rotated;
                WMODE_LATCH:  mask = BYTE_ONES;
                WMODE_SPREAD: src = {8{i_host_data[n]}};
                WMODE_MASKED: begin
                    src  = {8{i_set_reset[n]}};
                    mask = rotated & i_bit_mask;
                end
                default: src = rotated;
            endcase
            // Rotation already happened above, so in mode 0 the function sees rotated data on lanes without set/reset.
            case (i_func)
                FUNC_AND: alu = src & lat;
                FUNC_OR:  alu = src | lat;
                FUNC_XOR: alu = src ^ lat;
                default:  alu = src;
            endcase
            if (i_write_mode == WMODE_LATCH) begin
                alu = lat;
            end
        end

        // Masked positions keep the latch contents.
        assign o_map_data[8*n +: 8] = (alu & mask) | (lat & ~mask);
    end

endmodule // pgw_write_unit

//--- rtl/pgw_read_unit.sv
// Combinational read datapath: plain map select or colour compare.
// Assumes map data are the four bytes just returned by display memory.
module pgw_read_unit (
    // Map data
    input  wire logic [31:0] i_maps,
    // Control fields
    input  wire logic [3:0]  i_colour,
    input  wire logic [3:0]  i_participate,
    input  wire logic        i_compare,
    input  wire logic [1:0]  i_sel,
    // Host byte
    output logic      [7:0]  o_data
);
    logic [7:0] cmp;

    // A map mismatches only when it participates and its bit differs.
    for (genvar b = 0; b < 8; b++) begin : g_bit
        assign cmp[b] = &(~(i_participate & (i_colour ^
                        {i_maps[24+b], i_maps[16+b], i_maps[8+b], i_maps[b]})));
    end

    // Plain reads ignore the compare registers.
    assign o_data = i_compare ? cmp : i_maps[8*i_sel +: 8];

endmodule // pgw_read_unit

//--- rtl/pgw_top.sv
// Graphics controller datapath between host accesses and four display maps.
// Assumes host, register port and map memory share i_ref_clk; maps answer a
// read one cycle after o_map_re.

module pgw_top (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    // Register port: index (sel 0) and data (sel 1)
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic        i_io_data_sel,
    input  wire logic [7:0]  i_io_wdata,
    output logic      [7:0]  o_io_rdata,
    output logic             o_io_rvalid,
    // Host memory access
    input  wire logic        i_mem_rd,
    input  wire logic        i_mem_wr,
    input  wire logic [19:0] i_mem_addr,
    input  wire logic [7:0]  i_mem_wdata,
    output logic      [7:0]  o_mem_rdata,
    output logic             o_mem_rvalid,
    // Sequencer mode
    input  wire logic        i_seq_chain4,
    // Display maps
    output logic             o_map_re,
    output logic      [3:0]  o_map_we,
    output logic      [15:0] o_map_addr,
    output logic      [31:0] o_map_wdata,
    input  wire logic [31:0] i_map_rdata,
    // Display fetch and shift load
    input  wire logic [31:0] i_disp_maps,
    output logic      [31:0] o_shift_data,
    output logic             o_shift_256,
    // Mode status
    output logic             o_gfx_addressing,
    output logic             o_chargen_latch_en,
    output logic             o_odd_even_addressing
);
    import pgw_pkg::*;

    typedef struct packed {
        pgw_state_t                state;
        logic [3:0]                index;
        logic [NUM_REGS-1:0][7:0]  regs;
        logic [31:0]               latch;
        logic [1:0]                rd_sel;
        logic                      io_rvalid;
        logic [7:0]                io_rdata;
        logic                      mem_rvalid;
        logic [7:0]                mem_rdata;
        logic                      map_re;
        logic [3:0]                map_we;
        logic [15:0]               map_addr;
        logic [31:0]               map_wdata;
        logic [31:0]               shift_data;
        logic                      shift_256;
        logic                      gfx;
        logic                      chargen_en;
        logic                      odd_even;
    } pgw_regs_t;

    pgw_regs_t   q;
    pgw_regs_t   next_q;
    logic [7:0]  gm;
    logic [7:0]  wa;
    logic [7:0]  rf;
    logic [7:0]  bm;
    logic [17:0] win;
    logic        hit;
    logic [16:0] off;
    logic [15:0] map_addr;
    logic [3:0]  lanes;
    logic [1:0]  rsel;
    logic [31:0] wr_data;
    logic [7:0]  rd_byte;
    logic [31:0] ileave;

    // Register fields used by the datapath.
    assign gm = q.regs[IDX_MODE_CTRL];
    assign wa = q.regs[IDX_WINDOW_ADDR];
    assign rf = q.regs[IDX_ROTATE_FUNC];
    assign bm = q.regs[IDX_BIT_MASK];

    // Host address decode into window hit and offset.
    assign win = pgw_window(wa[WA_WIN_LSB +: 2], i_mem_addr);
    assign hit = win[17];
    assign off = win[16:0];

    // Map address and write lanes for the three addressing schemes.
    always_comb begin
        map_addr = off[15:0];
        lanes    = 4'hF;
        if (i_seq_chain4) begin
            map_addr = {2'h0, off[15:2]};
            lanes    = 4'h1 << off[1:0];
        end else if (wa[WA_CHAIN_OE]) begin
            map_addr = {off[15:1], off[16]};
            lanes    = off[0] ? 4'hA : 4'h5;
        end
    end

    // Map chosen for a plain read.
    always_comb begin
        rsel = q.regs[IDX_READ_PLANE][1:0];
        if (i_seq_chain4) begin
            rsel = off[1:0];
        end else if (gm[GM_ODD_EVEN]) begin
            rsel = {q.regs[IDX_READ_PLANE][1], off[0]};
        end
    end

    // Interleaved shift-load format for two-bit-per-pixel modes.
    always_comb begin
        ileave = '0;
        for (int k = 0; k < 4; k++) begin
            ileave[k]      = i_disp_maps[2*k];
            ileave[4+k]    = i_disp_maps[8+2*k];
            ileave[8+k]    = i_disp_maps[2*k+1];
            ileave[12+k]   = i_disp_maps[8+2*k+1];
            ileave[16+k]   = i_disp_maps[16+2*k];
            ileave[20+k]   = i_disp_maps[24+2*k];
            ileave[24+k]   = i_disp_maps[16+2*k+1];
            ileave[28+k]   = i_disp_maps[24+2*k+1];
        end
    end

    pgw_write_unit u_write (
        .i_host_data  (i_mem_wdata),
        .i_latch      (q.latch),
        .i_set_reset  (q.regs[IDX_SET_RESET][3:0]),
        .i_sr_enable  (q.regs[IDX_SR_ENABLE][3:0]),
        .i_rotate     (rf[ROT_CNT_LSB +: 3]),
        .i_func       (rf[ROT_FUNC_LSB +: 2]),
        .i_write_mode (gm[GM_WMODE_LSB +: 2]),
        .i_bit_mask   (bm),
        .o_map_data   (wr_data)
    );

    pgw_read_unit u_read (
        .i_maps        (i_map_rdata),
        .i_colour      (q.regs[IDX_COMPARE_COLOR][3:0]),
        .i_participate (q.regs[IDX_PARTICIPATION][3:0]),
        .i_compare     (gm[GM_READ_MODE]),
        .i_sel         (q.rd_sel),
        .o_data        (rd_byte)
    );

    // Next-state logic: register port, host access sequencing, mode outputs.
    always_comb begin
        next_q            = q;
        next_q.io_rvalid  = 1'b0;
        next_q.mem_rvalid = 1'b0;
        next_q.map_re     = 1'b0;
        next_q.map_we     = 4'h0;
        // Index port takes the index, data port reaches the indexed register.
        if (i_io_wr) begin
            if (!i_io_data_sel) begin
                next_q.index = i_io_wdata[3:0];
            end else if (q.index < 4'(NUM_REGS)) begin
                next_q.regs[q.index] = i_io_wdata & pgw_wmask(q.index);
            end
        end
        if (i_io_rd) begin
            next_q.io_rvalid = 1'b1;
            if (!i_io_data_sel) begin
                next_q.io_rdata = {4'h0, q.index};
            end else if (q.index < 4'(NUM_REGS)) begin
                next_q.io_rdata = q.regs[q.index];
            end else begin
                next_q.io_rdata = BYTE_ZERO;
            end
        end
        // Host accesses; a new one is taken only when idle.
        case (q.state)
            ST_IDLE: begin
                if (hit && i_mem_rd) begin
                    next_q.state    = ST_RD_ISSUE;
                    next_q.map_re   = 1'b1;
                    next_q.map_addr = map_addr;
                    next_q.rd_sel   = rsel;
                end else if (hit && i_mem_wr) begin
                    next_q.map_we    = lanes;
                    next_q.map_addr  = map_addr;
                    next_q.map_wdata = wr_data;
                end
            end
            ST_RD_ISSUE: begin
                next_q.state = ST_RD_DATA;
            end
            ST_RD_DATA: begin
                next_q.latch      = i_map_rdata;
                next_q.mem_rdata  = rd_byte;
                next_q.mem_rvalid = 1'b1;
                next_q.state      = ST_IDLE;
            end
            default: begin
                next_q.state = ST_IDLE;
            end
        endcase
        // Shift-load format and addressing status.
        next_q.shift_256  = gm[GM_SHIFT_256];
        if (gm[GM_SHIFT_256] || !gm[GM_SHIFT_IL]) begin
            next_q.shift_data = i_disp_maps;
        end else begin
            next_q.shift_data = ileave;
        end
        next_q.gfx        = wa[WA_GFX];
        next_q.chargen_en = !wa[WA_GFX];
        next_q.odd_even   = gm[GM_ODD_EVEN];
    end

    // State register.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q                    <= '0;
            q.state              <= ST_IDLE;
            q.regs[IDX_BIT_MASK] <= RST_BIT_MASK;
            q.chargen_en         <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register.
    assign o_io_rdata            = q.io_rdata;
    assign o_io_rvalid           = q.io_rvalid;
    assign o_mem_rdata           = q.mem_rdata;
    assign o_mem_rvalid          = q.mem_rvalid;
    assign o_map_re              = q.map_re;
    assign o_map_we              = q.map_we;
    assign o_map_addr            = q.map_addr;
    assign o_map_wdata           = q.map_wdata;
    assign o_shift_data          = q.shift_data;
    assign o_shift_256           = q.shift_256;
    assign o_gfx_addressing      = q.gfx;
    assign o_chargen_latch_en    = q.chargen_en;
    assign o_odd_even_addressing = q.odd_even;

    // Checks of the datapath against its cause.
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    logic [7:0] chk_cmp;

    // Independent colour-compare expectation over the latched maps.
    always_comb begin
        chk_cmp = BYTE_ONES;
        for (int b = 0; b < 8; b++) begin
            for (int n = 0; n < 4; n++) begin
                if (q.regs[IDX_PARTICIPATION][n] &&
                    (q.latch[8*n+b] != q.regs[IDX_COMPARE_COLOR][n])) begin
                    chk_cmp[b] = 1'b0;
                end
            end
        end
    end

    sequence s_rd_req;
        q.state == ST_IDLE && i_mem_rd && hit;
    endsequence
    sequence s_rd_answer;
        q.map_re ##2 o_mem_rvalid;
    endsequence

    property p_rd_latency;
        s_rd_req |=> s_rd_answer;
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read answer not three cycles");
    property p_latch_load;
        o_mem_rvalid |-> q.latch == $past(i_map_rdata);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latches not loaded by read");
    property p_chain4_read;
        (s_rd_req and (i_seq_chain4 && !gm[GM_READ_MODE])) |->
            ##3 o_mem_rdata == q.latch[8*$past(i_mem_addr[1:0], 3) +: 8];
    endproperty
    a_chain4_read: assert property (p_chain4_read) else $error("chain-4 read map wrong");
    property p_compare;
        o_mem_rvalid && $past(gm[GM_READ_MODE]) |-> o_mem_rdata == chk_cmp;
    endproperty
    a_compare: assert property (p_compare) else $error("colour compare result wrong");
    property p_wm1;
        q.map_we != 4'h0 && gm[1:0] == WMODE_LATCH |-> o_map_wdata == q.latch;
    endproperty
    a_wm1: assert property (p_wm1) else $error("mode 1 did not write latches");
    property p_wm0;
        q.map_we != 4'h0 && gm[1:0] == WMODE_SR && rf == BYTE_ZERO &&
            q.regs[IDX_SR_ENABLE] == BYTE_ZERO |->
            o_map_wdata == ({4{$past(i_mem_wdata) & bm}} | (q.latch & ~{4{bm}}));
    endproperty
    a_wm0: assert property (p_wm0) else $error("mode 0 masked write wrong");
    property p_wm2;
        q.map_we != 4'h0 && gm[1:0] == WMODE_SPREAD && rf == BYTE_ZERO |->
            o_map_wdata[31:24] == (({8{$past(i_mem_wdata[3])}} & bm) | (q.latch[31:24] & ~bm));
    endproperty
    a_wm2: assert property (p_wm2) else $error("mode 2 spread wrong");
    property p_wm3;
        q.map_we != 4'h0 && gm[1:0] == WMODE_MASKED && rf == BYTE_ZERO |->
            o_map_wdata[7:0] == (({8{q.regs[IDX_SET_RESET][0]}} & $past(i_mem_wdata) & bm)
                                 | (q.latch[7:0] & ~($past(i_mem_wdata) & bm)));
    endproperty
    a_wm3: assert property (p_wm3) else $error("mode 3 write wrong");
    property p_index;
        i_io_wr && !i_io_data_sel |=> q.index == $past(i_io_wdata[3:0]);
    endproperty
    a_index: assert property (p_index) else $error("index not taken");
    property p_reserved;
        i_io_rd && i_io_data_sel && q.index == IDX_ROTATE_FUNC |=>
            o_io_rvalid && o_io_rdata[7:5] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
    property p_window;
        q.state == ST_IDLE && i_mem_wr && !i_mem_rd && !hit |=> q.map_we == 4'h0;
    endproperty
    a_window: assert property (p_window) else $error("write outside window taken");

endmodule // pgw_top

//--- verif/pgw_map_model.sv
// Behavioural model of the four display maps behind the datapath.
// Assumes only the low byte of the map address is used by the bench.
module pgw_map_model (
    // Clock
    input  wire logic        i_clk,
    // Map access from the datapath
    input  wire logic        i_re,
    input  wire logic [3:0]  i_we,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    // Read answer, valid only in the cycle after a read strobe
    output logic      [31:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [256];

    // Lane writes; outside a read answer the data bus is inverted so it is never stale.
    always_ff @(posedge i_clk) begin
        for (int n = 0; n < 4; n++) begin
            if (i_we[n]) mem[i_addr][8*n +: 8] <= i_wdata[8*n +: 8];
        end
        o_rdata <= i_re ? mem[i_addr] : ~o_rdata;
    end
endmodule // pgw_map_model

//--- verif/pgw_top_tb.sv
// Self-checking bench of the graphics write/read datapath.
// Assumes the map model answers one cycle after each map read strobe.
module pgw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pgw_pkg::*;
    logic        clk = 0, rst_b = 0, io_wr = 0, io_rd = 0, io_sel = 0, mem_rd = 0, mem_wr = 0;
    logic [7:0]  io_wd = 8'h00, mem_wd = 8'h00, io_rdata, mem_rdata;
    logic [19:0] mem_addr = 20'h00000;
    logic [31:0] disp = 32'h00000000, map_wdata, map_rdata, shift_data;
    logic        io_rv, mem_rv, map_re, shift_256, gfx, cg_en, oe_addr, chain4 = 0;
    logic [3:0]  map_we;
    logic [15:0] map_addr;
    int          bad_count = 0, n_checks = 0, cyc = 0;

    pgw_top pgw_top_inst (.i_ref_clk(clk), .i_rst_b(rst_b), .i_io_wr(io_wr), .i_io_rd(io_rd),
        .i_io_data_sel(io_sel), .i_io_wdata(io_wd), .o_io_rdata(io_rdata), .o_io_rvalid(io_rv),
        .i_mem_rd(mem_rd), .i_mem_wr(mem_wr), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wd),
        .o_mem_rdata(mem_rdata), .o_mem_rvalid(mem_rv), .i_seq_chain4(chain4), .o_map_re(map_re),
        .o_map_we(map_we), .o_map_addr(map_addr), .o_map_wdata(map_wdata),
        .i_map_rdata(map_rdata), .i_disp_maps(disp), .o_shift_data(shift_data),
        .o_shift_256(shift_256), .o_gfx_addressing(gfx), .o_chargen_latch_en(cg_en),
        .o_odd_even_addressing(oe_addr));
    pgw_map_model pgw_map_model_inst (.i_clk(clk), .i_re(map_re), .i_we(map_we),
        .i_addr(map_addr[7:0]), .i_wdata(map_wdata), .o_rdata(map_rdata));

    // Clock of 8 ns and a cycle counter that cuts a hang short.
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Index write, then one access on the data port.
    task automatic reg_wr(input logic [3:0] idx, input logic [7:0] v);
        @(negedge clk); io_sel = 0; io_wd = {4'h0, idx}; io_wr = 1;
        @(negedge clk); io_sel = 1; io_wd = v;
        @(negedge clk); io_wr = 0;
    endtask

    task automatic reg_rd(input logic [3:0] idx, input logic [7:0] exp);
        @(negedge clk); io_sel = 0; io_wd = {4'h0, idx}; io_wr = 1;
        @(negedge clk); io_wr = 0; io_sel = 1; io_rd = 1;
        @(negedge clk); io_rd = 0;
        for (int k = 0; k < 4 && io_rv !== 1'b1; k++) @(negedge clk);
        chk("io_rvalid", 1, io_rv);
        chk("io_rdata", exp, io_rdata);
    endtask

    task automatic mem_write(input logic [19:0] a, input logic [7:0] d);
        @(negedge clk); mem_addr = a; mem_wd = d; mem_wr = 1;
        @(negedge clk); mem_wr = 0;
    endtask

    // A refused read (ok = 0) must stay unanswered for the whole wait.
    task automatic mem_read(input logic [19:0] a, input logic [7:0] exp, input logic ok);
        @(negedge clk); mem_addr = a; mem_rd = 1;
        @(negedge clk); mem_rd = 0;
        for (int k = 0; k < 5 && mem_rv !== 1'b1; k++) @(negedge clk);
        chk("mem_rvalid", ok, mem_rv);
        if (ok) chk("mem_rdata", exp, mem_rdata);
    endtask

    task automatic rd_map(input logic [19:0] a, input logic [7:0] n, input logic [7:0] exp);
        reg_wr(IDX_READ_PLANE, n);
        mem_read(a, exp, 1'b1);
    endtask

    task automatic t_regs();
        reg_rd(IDX_BIT_MASK, 8'hFF);
        reg_wr(IDX_MODE_CTRL, 8'hFF);
        reg_rd(IDX_MODE_CTRL, 8'h7B);
        reg_wr(IDX_ROTATE_FUNC, 8'hFF);
        reg_rd(IDX_ROTATE_FUNC, 8'h1F);
    endtask

    // Set/reset on maps 0 and 1, rotated host byte 81 ORed with clear latches on maps 2 and 3.
    task automatic t_mode0();
        reg_wr(IDX_SET_RESET, 8'h05);
        reg_wr(IDX_SR_ENABLE, 8'h03);
        reg_wr(IDX_ROTATE_FUNC, 8'h11);
        reg_wr(IDX_MODE_CTRL, 8'h00);
        mem_write(20'hA0000, 8'h81);
        rd_map(20'hA0000, 8'h00, 8'hFF);
        rd_map(20'hA0000, 8'h01, 8'h00);
        rd_map(20'hA0000, 8'h02, 8'hC0);
        rd_map(20'hA0000, 8'h03, 8'hC0);
    endtask

    // AND is selected so that a function wrongly applied in mode 1 would show.
    task automatic t_mode1();
        reg_wr(IDX_ROTATE_FUNC, 8'h08);
        reg_wr(IDX_MODE_CTRL, 8'h01);
        mem_write(20'hA0001, 8'h00);
        rd_map(20'hA0001, 8'h02, 8'hC0);
        rd_map(20'hA0001, 8'h00, 8'hFF);
    endtask

    // Latches hold FF,00,C0,C0; spread 05, XOR, mask 0F.
    task automatic t_mode2();
        reg_wr(IDX_ROTATE_FUNC, 8'h18);
        reg_wr(IDX_BIT_MASK, 8'h0F);
        reg_wr(IDX_MODE_CTRL, 8'h02);
        mem_write(20'hA0001, 8'h05);
        rd_map(20'hA0001, 8'h00, 8'hF0);
        rd_map(20'hA0001, 8'h02, 8'hCF);
    endtask

    // Latches hold F0,00,CF,C0; host byte 3C becomes the mask.
    task automatic t_mode3();
        reg_wr(IDX_ROTATE_FUNC, 8'h00);
        reg_wr(IDX_BIT_MASK, 8'hFF);
        reg_wr(IDX_MODE_CTRL, 8'h03);
        mem_write(20'hA0001, 8'h3C);
        rd_map(20'hA0001, 8'h00, 8'hFC);
        rd_map(20'hA0001, 8'h03, 8'hC0);
    endtask

    task automatic t_compare();
        reg_wr(IDX_COMPARE_COLOR, 8'h05);
        reg_wr(IDX_PARTICIPATION, 8'h07);
        reg_wr(IDX_MODE_CTRL, 8'h08);
        mem_read(20'hA0000, 8'hC0, 1'b1);
        reg_wr(IDX_PARTICIPATION, 8'h0F);
        mem_read(20'hA0000, 8'h00, 1'b1);
    endtask

    // Chain-4 picks map and lane by A1:A0; chain odd/even pairs lanes by A0.
    task automatic t_chains();
        reg_wr(IDX_MODE_CTRL, 8'h00);
        reg_wr(IDX_SR_ENABLE, 8'h00);
        reg_wr(IDX_ROTATE_FUNC, 8'h19);
        chain4 = 1'b1;
        mem_read(20'hA0002, 8'hC0, 1'b1);
        mem_write(20'hA0006, 8'h5A);
        mem_read(20'hA0006, 8'hED, 1'b1);
        chain4 = 1'b0;
        reg_wr(IDX_ROTATE_FUNC, 8'h00);
        reg_wr(IDX_WINDOW_ADDR, 8'h02);
        reg_wr(IDX_MODE_CTRL, 8'h12);
        mem_write(20'hB0001, 8'h02);
        chk("map_we", 32'hA, map_we);
        rd_map(20'hB0001, 8'h02, 8'h00);
        rd_map(20'hB0001, 8'h00, 8'hFF);
    endtask

    // Windows 10 and 01 refuse B8000 and B0000; window 11 refuses A0000.
    task automatic t_window();
        reg_wr(IDX_MODE_CTRL, 8'h00);
        reg_wr(IDX_WINDOW_ADDR, 8'h09);
        mem_read(20'hB8000, 8'h00, 1'b0);
        reg_wr(IDX_WINDOW_ADDR, 8'h05);
        mem_read(20'hB0000, 8'h00, 1'b0);
        reg_wr(IDX_WINDOW_ADDR, 8'h0D);
        mem_read(20'hA0000, 8'h00, 1'b0);
        mem_read(20'hB8000, 8'hFF, 1'b1);
        mem_write(20'hB8001, 8'h5A);
        chk("map_we", 32'hF, map_we);
        mem_write(20'hA0001, 8'h5A);
        chk("map_we", 32'h0, map_we);
        chk("gfx", 1, gfx);
        chk("chargen", 0, cg_en);
    endtask

    task automatic t_shift();
        disp = 32'hFFAA0055;
        reg_wr(IDX_MODE_CTRL, 8'h20);
        repeat (2) @(negedge clk);
        chk("shift_il", 32'hFFF0000F, shift_data);
        reg_wr(IDX_MODE_CTRL, 8'h70);
        repeat (2) @(negedge clk);
        chk("shift_256", 1, shift_256);
        chk("shift_data", 32'hFFAA0055, shift_data);
        chk("odd_even", 1, oe_addr);
    endtask

    // Reset for 10 cycles, then the scenarios in order.
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1;
        t_regs();
        t_mode0();
        t_mode1();
        t_mode2();
        t_mode3();
        t_compare();
        t_chains();
        t_window();
        t_shift();
        print_verdict();
    end
endmodule // pgw_top_tb
